// *** cffr_apb_slave.sv ***
// apb slave front end with zero wait states
`timescale 1ns/1ps
module cffr_apb_slave
  import cffr_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // apb
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // register side
  cffr_reg_if.bus          rif
);

  typedef enum logic [0:0] {
    ST_IDLE   = 1'b0,
    ST_ACCESS = 1'b1
  } cffr_apb_st_t;

  cffr_apb_st_t state_ff;
  cffr_apb_st_t nxt_state;
  logic [31:0]  prdata_ff;
  logic [31:0]  nxt_prdata;
  logic         ok;

  // address decode
  assign rif.idx   = cffr_addr_idx(i_paddr);
  assign rif.wdata = i_pwdata[15:0];
  assign ok        = rif.hit && cffr_aligned(i_paddr);

  // write takes effect at the access edge
  assign rif.wr    = (state_ff == ST_ACCESS) && i_psel && i_penable && i_pwrite && ok;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !ok;
  assign o_prdata  = prdata_ff;

  // phase tracking and read capture in setup
  always_comb begin
    nxt_state  = state_ff;
    nxt_prdata = prdata_ff;
    case (state_ff)
      ST_IDLE: begin
        if (i_psel && !i_penable) begin
          nxt_state  = ST_ACCESS;
          nxt_prdata = (ok && !i_pwrite) ? {16'h0000, rif.rdata} : 32'h0000_0000;
        end
      end
      ST_ACCESS: begin
        if (i_psel && i_penable) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_ff  <= ST_IDLE;
      prdata_ff <= 32'h0000_0000;
    end else begin
      state_ff  <= nxt_state;
      prdata_ff <= nxt_prdata;
    end
  end

endmodule : cffr_apb_slave

// *** cffr_flag_bank.sv ***
// sticky fault flags: hardware sets, write-zero or summary clears
`timescale 1ns/1ps
module cffr_flag_bank
  import cffr_pkg::*;
#(
  parameter int WIDTH = 12
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  // events and clears
  input  wire logic [WIDTH-1:0] i_set,
  input  wire logic             i_wr,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic             i_sum_clr,
  // flags
  output logic      [WIDTH-1:0] o_flags
);

  logic [WIDTH-1:0] flags_ff;
  logic [WIDTH-1:0] nxt_flags;
  logic [WIDTH-1:0] clr;

  // clear mask, detection wins over any clear
  always_comb begin
    clr = '0;
    if (i_wr) begin
      clr = ~i_wdata;               // see [R11]
    end
    if (i_sum_clr) begin
      clr = '1;                     // see [R10]
    end
    nxt_flags = (flags_ff & ~clr) | i_set; // see [R11]
  end

  // flag registers, kept through sleep, cleared by reset and by write-zero or summary clears
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      flags_ff <= CFFR_RST_FLAGS[WIDTH-1:0]; // see [R7]
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign o_flags = flags_ff;

endmodule : cffr_flag_bank

// *** cffr_pkg.sv ***
// constants and helpers for the cell fault flag register bank
package cffr_pkg;

  // register indexes, byte address is four times the index
  localparam logic [5:0] CFFR_IDX_GENERAL_DIAGNOSIS_SUMMARY = 6'h0B;
  localparam logic [5:0] CFFR_IDX_CELL_UNDERVOLTAGE_FLAGS  = 6'h0C;
  localparam logic [5:0] CFFR_IDX_CELL_OVERVOLTAGE_FLAGS  = 6'h0D;
  localparam logic [5:0] CFFR_IDX_EXT_TEMP = 6'h0E;
  localparam logic [5:0] CFFR_IDX_EXT_THR  = 6'h12;

  // geometry
  localparam int CFFR_NUM_CELLS = 12;
  localparam int CFFR_NUM_EXT   = 5;
  localparam int CFFR_EXT_BITS  = 15;
  localparam int CFFR_RES_W     = 16;

  // field positions
  localparam int CFFR_SUM_UV_BIT  = 12;
  localparam int CFFR_SUM_OV_BIT  = 13;
  localparam int CFFR_SUM_EXT_BIT = 10;
  localparam int CFFR_EXT_OT_OFS  = 2;
  localparam int CFFR_EXT_SH_OFS  = 1;
  localparam int CFFR_EXT_OL_OFS  = 0;

  // reset values
  localparam logic [15:0] CFFR_RST_FLAGS   = 16'h0000;
  localparam logic [15:0] CFFR_RST_EXT_THR = 16'h0000;

  // byte address to register index
  function automatic logic [5:0] cffr_addr_idx(input logic [7:0] addr);
    cffr_addr_idx = addr[7:2];
  endfunction : cffr_addr_idx

  // word alignment check
  function automatic logic cffr_aligned(input logic [7:0] addr);
    cffr_aligned = (addr[1:0] == 2'h0);
  endfunction : cffr_aligned

endpackage : cffr_pkg

// *** cffr_reg_if.sv ***
// register access carrier between the bus slave and the register bank
`timescale 1ns/1ps
interface cffr_reg_if;
  logic        wr;
  logic [5:0]  idx;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        hit;

  // bus side drives requests
  modport bus (output wr, idx, wdata, input rdata, hit);
  // register side answers
  modport regs (input wr, idx, wdata, output rdata, hit);
endinterface : cffr_reg_if

// *** cffr_top.sv ***
// cell and external temperature fault flag register bank with apb access
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps

// Operation
// [R1] Bits 11..0 of the undervoltage register hold one sticky undervoltage flag per cell, reset 0.
// [R2] Writing zero to a summary bit of the general diagnosis register clears the cell flags too.
// [R3] A cell with its undervoltage flag set has its balancing switch held off.
// [R4] Bits 15..12 of both cell flag registers are reserved and reset to zero.
// [R5] Bits 11..0 of the overvoltage register at 0x0D hold one overvoltage flag per cell, reset 0.
// [R6] A cell with its overvoltage flag set has balancing held off, other cells unaffected.
// [R7] The overvoltage register resets to 0x0000 and keeps its flags through sleep.
// [R8] The external register at 0x0E holds overheat, short and open flags at 3n+2, 3n+1, 3n.
// [R9] An external channel's overheat flag sets when its result is below the threshold.
// [R10] Clearing summary bit 12 or 13 clears all flags of the matching cell register.
// [R11] Flags set only by detection, stay set, and a direct write clears bits written as zero.
module cffr_top
  import cffr_pkg::*;
#(
  parameter int NUM_CELLS = CFFR_NUM_CELLS,
  parameter int NUM_EXT   = CFFR_NUM_EXT,
  parameter int RES_W     = CFFR_RES_W
) (
  // clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_sys_rst,
  // apb slave
  input  wire logic                     i_psel,
  input  wire logic                     i_penable,
  input  wire logic                     i_pwrite,
  input  wire logic [7:0]               i_paddr,
  input  wire logic [31:0]              i_pwdata,
  output logic      [31:0]              o_prdata,
  output logic                          o_pready,
  output logic                          o_pslverr,
  // cell comparator detections, one-cycle pulses or levels
  input  wire logic [NUM_CELLS-1:0]     i_cell_undervoltage_flags_det,
  input  wire logic [NUM_CELLS-1:0]     i_cell_overvoltage_flags_det,
  // external temperature channels
  input  wire logic [NUM_EXT-1:0]       i_ext_valid,
  input  wire logic [NUM_EXT*RES_W-1:0] i_ext_result,
  input  wire logic [NUM_EXT-1:0]       i_ext_short_det,
  input  wire logic [NUM_EXT-1:0]       i_ext_open_det,
  // balancing
  input  wire logic [NUM_CELLS-1:0]     i_bal_req,
  output logic      [NUM_CELLS-1:0]     o_bal_en,
  // flag status
  output logic      [NUM_CELLS-1:0]     o_cell_low_flag_n,
  output logic      [NUM_CELLS-1:0]     o_cell_high_flag_n,
  output logic      [3*NUM_EXT-1:0]     o_ext_flags
);

  cffr_reg_if rif ();

  logic [NUM_CELLS-1:0] uv_flags;
  logic [NUM_CELLS-1:0] ov_flags;
  logic [3*NUM_EXT-1:0] ext_flags;
  logic [3*NUM_EXT-1:0] ext_set;
  logic [RES_W-1:0]     thr_ff;
  logic [RES_W-1:0]     nxt_thr;
  logic [NUM_CELLS-1:0] bal_ff;
  logic [NUM_CELLS-1:0] nxt_bal;
  logic                 wr_gen;
  logic                 wr_uv;
  logic                 wr_ov;
  logic                 wr_ext;
  logic                 wr_thr;
  logic                 clr_uv;
  logic                 clr_ov;
  logic                 clr_ext;
  logic                 sum_uv;
  logic                 sum_ov;
  logic                 sum_ext;

  // bus front end
  cffr_apb_slave u_apb (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_psel    (i_psel),
    .i_penable (i_penable),
    .i_pwrite  (i_pwrite),
    .i_paddr   (i_paddr),
    .i_pwdata  (i_pwdata),
    .o_prdata  (o_prdata),
    .o_pready  (o_pready),
    .o_pslverr (o_pslverr),
    .rif       (rif.bus)
  );

  // write strobes per register
  assign wr_gen = rif.wr && (rif.idx == CFFR_IDX_GENERAL_DIAGNOSIS_SUMMARY);
  assign wr_uv  = rif.wr && (rif.idx == CFFR_IDX_CELL_UNDERVOLTAGE_FLAGS);
  assign wr_ov  = rif.wr && (rif.idx == CFFR_IDX_CELL_OVERVOLTAGE_FLAGS);
  assign wr_ext = rif.wr && (rif.idx == CFFR_IDX_EXT_TEMP);
  assign wr_thr = rif.wr && (rif.idx == CFFR_IDX_EXT_THR);

  // summary write-zero clears the detailed register
  assign clr_uv  = wr_gen && !rif.wdata[CFFR_SUM_UV_BIT];  // see [R2]
  assign clr_ov  = wr_gen && !rif.wdata[CFFR_SUM_OV_BIT];  // see [R2]
  assign clr_ext = wr_gen && !rif.wdata[CFFR_SUM_EXT_BIT];

  // undervoltage flags
  cffr_flag_bank #(
    .WIDTH (NUM_CELLS)
  ) u_uv (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_set     (i_cell_undervoltage_flags_det),   // see [R1]
    .i_wr      (wr_uv),
    .i_wdata   (rif.wdata[NUM_CELLS-1:0]),
    .i_sum_clr (clr_uv),          // see [R10]
    .o_flags   (uv_flags)
  );

  // overvoltage flags
  cffr_flag_bank #(
    .WIDTH (NUM_CELLS)
  ) u_ov (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_set     (i_cell_overvoltage_flags_det),   // see [R5]
    .i_wr      (wr_ov),
    .i_wdata   (rif.wdata[NUM_CELLS-1:0]),
    .i_sum_clr (clr_ov),          // see [R10]
    .o_flags   (ov_flags)
  );

  // external channel events, three flags per channel
  for (genvar n = 0; n < NUM_EXT; n++) begin : g_ext
    assign ext_set[3*n+CFFR_EXT_OT_OFS] = i_ext_valid[n] &&
      (i_ext_result[n*RES_W +: RES_W] < thr_ff);          // see [R9]
    assign ext_set[3*n+CFFR_EXT_SH_OFS] = i_ext_short_det[n]; // see [R8]
    assign ext_set[3*n+CFFR_EXT_OL_OFS] = i_ext_open_det[n];  // see [R8]
  end

  // external temperature flags
  cffr_flag_bank #(
    .WIDTH (3*NUM_EXT)
  ) u_ext (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_set     (ext_set),
    .i_wr      (wr_ext),
    .i_wdata   (rif.wdata[3*NUM_EXT-1:0]),
    .i_sum_clr (clr_ext),
    .o_flags   (ext_flags)
  );

  // summary bits follow the detailed registers
  assign sum_uv  = |uv_flags;
  assign sum_ov  = |ov_flags;
  assign sum_ext = |ext_flags;

  // threshold and balancing next values
  always_comb begin
    nxt_thr = thr_ff;
    if (wr_thr) begin
      nxt_thr = rif.wdata[RES_W-1:0];
    end
    nxt_bal = i_bal_req & ~uv_flags & ~ov_flags;  // see [R3] see [R6]
  end

  // threshold and balancing registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      thr_ff <= CFFR_RST_EXT_THR;
      bal_ff <= '0;
    end else begin
      thr_ff <= nxt_thr;
      bal_ff <= nxt_bal;
    end
  end

  // read mux, reserved bits read zero
  always_comb begin
    rif.rdata = 16'h0000;
    rif.hit   = 1'b1;
    case (rif.idx)
      CFFR_IDX_GENERAL_DIAGNOSIS_SUMMARY: begin
        rif.rdata[CFFR_SUM_UV_BIT]  = sum_uv;
        rif.rdata[CFFR_SUM_OV_BIT]  = sum_ov;
        rif.rdata[CFFR_SUM_EXT_BIT] = sum_ext;
      end
      CFFR_IDX_CELL_UNDERVOLTAGE_FLAGS: begin
        rif.rdata[NUM_CELLS-1:0] = uv_flags;   // see [R4]
      end
      CFFR_IDX_CELL_OVERVOLTAGE_FLAGS: begin
        rif.rdata[NUM_CELLS-1:0] = ov_flags;   // see [R4]
      end
      CFFR_IDX_EXT_TEMP: begin
        rif.rdata[3*NUM_EXT-1:0] = ext_flags;  // see [R8]
      end
      CFFR_IDX_EXT_THR: begin
        rif.rdata[RES_W-1:0] = thr_ff;
      end
      default: rif.hit = 1'b0;
    endcase
  end

  // status outputs
  assign o_bal_en           = bal_ff;
  assign o_cell_low_flag_n  = uv_flags;
  assign o_cell_high_flag_n = ov_flags;
  assign o_ext_flags        = ext_flags;

endmodule : cffr_top

// *** cffr_top_chk.sv ***
// assertions on the fault flag register bank ports
`timescale 1ns/1ps
module cffr_chk #(
  parameter int NUM_CELLS = 12
) (
  // clock, reset and apb
  input wire logic                 i_clk,
  input wire logic                 i_sys_rst,
  input wire logic                 i_psel,
  input wire logic                 i_penable,
  input wire logic                 i_pwrite,
  input wire logic [7:0]           i_paddr,
  input wire logic [31:0]          i_pwdata,
  input wire logic [31:0]          o_prdata,
  input wire logic                 o_pslverr,
  // cells and balancing
  input wire logic [NUM_CELLS-1:0] i_cell_undervoltage_flags_det,
  input wire logic [NUM_CELLS-1:0] i_cell_overvoltage_flags_det,
  input wire logic [NUM_CELLS-1:0] i_bal_req,
  input wire logic [NUM_CELLS-1:0] o_bal_en,
  input wire logic [NUM_CELLS-1:0] o_cell_low_flag_n,
  input wire logic [NUM_CELLS-1:0] o_cell_high_flag_n
);
  // access phase and write access
  wire logic acc = i_psel & i_penable;
  wire logic wr  = acc & i_pwrite;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  property p_uv_set;
    1 |=> &(o_cell_low_flag_n | ~$past(i_cell_undervoltage_flags_det));
  endproperty
  a_uv_set: assert property (p_uv_set) else $error("uv flag missed");
  property p_ov_set;
    1 |=> &(o_cell_high_flag_n | ~$past(i_cell_overvoltage_flags_det));
  endproperty
  a_ov_set: assert property (p_ov_set) else $error("ov flag missed");
  property p_sticky;
    |($past(o_cell_low_flag_n) & ~o_cell_low_flag_n) |-> $past(wr) || $past(i_sys_rst);
  endproperty
  a_sticky: assert property (p_sticky) else $error("uv flag lost");
  property p_bal;
    1 |=> o_bal_en == $past(i_bal_req & ~o_cell_low_flag_n & ~o_cell_high_flag_n);
  endproperty
  a_bal: assert property (p_bal) else $error("balancing wrong");
  property p_err;
    acc |-> o_pslverr == !(i_paddr inside {8'h2C, 8'h30, 8'h34, 8'h38, 8'h48});
  endproperty
  a_err: assert property (p_err) else $error("slave error wrong");
  property p_rd_uv;
    acc && !i_pwrite && i_paddr == 8'h30 |-> o_prdata == 32'($past(o_cell_low_flag_n));
  endproperty
  a_rd_uv: assert property (p_rd_uv) else $error("uv read wrong");
  property p_sum_clr;
    wr && i_paddr == 8'h2C && !i_pwdata[12] |=> o_cell_low_flag_n == $past(i_cell_undervoltage_flags_det);
  endproperty
  a_sum_clr: assert property (p_sum_clr) else $error("summary clear");
  property p_wr_clr;
    wr && i_paddr == 8'h30 |=> o_cell_low_flag_n ==
      $past((o_cell_low_flag_n & i_pwdata[NUM_CELLS-1:0]) | i_cell_undervoltage_flags_det);
  endproperty
  a_wr_clr: assert property (p_wr_clr) else $error("direct clear");
endmodule : cffr_chk

bind cffr_top cffr_chk #(.NUM_CELLS(NUM_CELLS)) u_chk (.i_clk, .i_sys_rst, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pslverr, .i_cell_undervoltage_flags_det,
  .i_cell_overvoltage_flags_det, .i_bal_req, .o_bal_en, .o_cell_low_flag_n, .o_cell_high_flag_n);

// *** tb_top.sv ***
// self-checking bench for the fault flag register bank
`timescale 1ns/1ps
module tb_top;
  logic        i_clk, i_sys_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, er;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd, e;
  logic [11:0] i_cell_undervoltage_flags_det, i_cell_overvoltage_flags_det, i_bal_req, o_bal_en, uv, ov, w;
  logic [11:0] o_cell_low_flag_n, o_cell_high_flag_n;
  logic [4:0]  i_ext_valid, i_ext_short_det, i_ext_open_det, sh, op;
  logic [79:0] i_ext_result, res;
  logic [14:0] o_ext_flags;
  logic [15:0] thr;
  logic [7:0]  adr [5] = '{8'h2C, 8'h30, 8'h34, 8'h38, 8'h48};
  logic [7:0]  bad [3] = '{8'h31, 8'h3C, 8'h4C};
  int          fails, samples_checked;

  cffr_top dut (.i_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_cell_undervoltage_flags_det, .i_cell_overvoltage_flags_det, .i_ext_valid,
    .i_ext_result, .i_ext_short_det, .i_ext_open_det, .i_bal_req, .o_bal_en,
    .o_cell_low_flag_n, .o_cell_high_flag_n, .o_ext_flags);

  // 25 mhz clock
  always #20 i_clk = ~i_clk;

  // count and compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, answer taken at the pready edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do
      @(posedge i_clk);
    while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  // read and compare
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
  endtask : rdc

  // one-cycle detection pulses
  task automatic det(input logic [11:0] u, input logic [11:0] v);
    @(posedge i_clk);
    i_cell_undervoltage_flags_det <= u;
    i_cell_overvoltage_flags_det <= v;
    @(posedge i_clk);
    i_cell_undervoltage_flags_det <= 12'h000;
    i_cell_overvoltage_flags_det <= 12'h000;
  endtask : det

  // expected external flag word
  function automatic logic [31:0] f_ext(input logic [79:0] r, input logic [15:0] t,
                                        input logic [4:0] s, input logic [4:0] o);
    f_ext = 32'h0;
    for (int n = 0; n < 5; n++)
      f_ext[3*n +: 3] = {r[16*n +: 16] < t, s[n], o[n]};
  endfunction : f_ext

  // verdict and end of run
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // watchdog
  initial begin
    repeat (3000) @(posedge i_clk);
    fails++;
    give_verdict();
  end

  // main sequence
  initial begin
    {i_clk, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_ext_result} = '0;
    {i_cell_undervoltage_flags_det, i_cell_overvoltage_flags_det, i_bal_req, i_ext_valid} = '0;
    {i_ext_short_det, i_ext_open_det, fails, samples_checked} = '0;
    i_sys_rst = 1'b1;
    void'($urandom(93207));
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    foreach (adr[i]) rdc(adr[i], 32'h0);
    // random detections, direct and summary clears
    repeat (4) begin
      uv = 12'($urandom);
      ov = 12'($urandom);
      w = 12'($urandom);
      i_bal_req <= 12'($urandom);
      det(uv, ov);
      rdc(8'h30, 32'(uv));
      rdc(8'h34, 32'(ov));
      chk(32'(o_bal_en), 32'(i_bal_req & ~(uv | ov)));
      chk(32'(o_cell_low_flag_n), 32'(uv));
      chk(32'(o_cell_high_flag_n), 32'(ov));
      rdc(8'h2C, {18'h0, |ov, |uv, 12'h0});
      apb(1'b1, 8'h30, {20'hFFFFF, w});
      rdc(8'h30, 32'(uv & w));
      apb(1'b1, 8'h34, {20'hFFFFF, ~w});
      rdc(8'h34, 32'(ov & ~w));
      apb(1'b1, 8'h2C, 32'h0000EFFF);
      rdc(8'h30, 32'h0);
      rdc(8'h34, 32'(ov & ~w));
      apb(1'b1, 8'h2C, 32'h0);
      rdc(8'h34, 32'h0);
    end
    // detection held through a clearing write
    i_cell_undervoltage_flags_det <= 12'h801;
    apb(1'b1, 8'h30, 32'h0);
    i_cell_undervoltage_flags_det <= 12'h000;
    rdc(8'h30, 32'h801);
    // external channels against a threshold
    thr = 16'($urandom) | 16'h8000;
    apb(1'b1, 8'h48, 32'(thr));
    rdc(8'h48, 32'(thr));
    res = 80'({$urandom, $urandom, $urandom});
    res[31:0] = 32'hFFFF0000;
    sh = 5'($urandom);
    op = 5'($urandom);
    e = f_ext(res, thr, sh, op);
    i_ext_result <= res;
    i_ext_valid <= 5'h1F;
    i_ext_short_det <= sh;
    i_ext_open_det <= op;
    @(posedge i_clk);
    {i_ext_valid, i_ext_short_det, i_ext_open_det} <= 15'h0;
    rdc(8'h38, e);
    chk(32'(o_ext_flags), e);
    rdc(8'h2C, 32'h0000_1400);
    apb(1'b1, 8'h38, 32'h0000AAAA);
    rdc(8'h38, e & 32'h2AAA);
    apb(1'b1, 8'h2C, 32'h0000FBFF);
    rdc(8'h38, 32'h0);
    // refused addresses leave the flags alone
    foreach (bad[i]) begin
      apb(1'b1, bad[i], 32'h0);
      rdc(bad[i], 32'h0);
      chk(32'(er), 32'h1);
    end
    rdc(8'h30, 32'h801);
    // second reset in mid-run, flags set just before it
    det(12'h000, 12'hA5A);
    rdc(8'h34, 32'h0000_0A5A);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rdc(8'h34, 32'h0);
    rdc(8'h30, 32'h0);
    give_verdict();
  end
endmodule : tb_top
